// ===== logic/acfp_defs.svh
// register offsets, field positions, reset values and timing counts
`ifndef ACFP_DEFS_SVH
`define ACFP_DEFS_SVH
`define ACFP_IDX_PWR2      6'h02
`define ACFP_IDX_CTRL      6'h0e
`define ACFP_IDX_VOL       6'h0f
`define ACFP_IDX_NA0H      6'h1b
`define ACFP_IDX_NA0L      6'h1c
`define ACFP_IDX_NA1H      6'h1d
`define ACFP_IDX_NA1L      6'h1e
`define ACFP_IDX_RATE      6'h07
`define ACFP_BIT_ON        0
`define ACFP_BIT_INV       0
`define ACFP_BIT_OSR       3
`define ACFP_BIT_HPAPP     7
`define ACFP_BIT_HPON      8
`define ACFP_BIT_NFON      7
`define ACFP_BIT_COMMIT    8
`define ACFP_RST_PWR2      9'h000
`define ACFP_RST_CTRL      9'h100
`define ACFP_RST_VOL       9'h0ff
`define ACFP_RST_NOTCH     9'h000
`define ACFP_RST_RATE      9'h000
`define ACFP_OSR_LO        8'h40
`define ACFP_OSR_HI        8'h80
`define ACFP_AUDIO_SHIFT   13
`endif

// ===== logic/acfp_pkg.sv
// types for the capture filter path
package acfp_pkg;
  typedef struct packed {
    logic        valid;
    logic [23:0] data;
  } acfp_sample_t;
  typedef enum logic [1:0] {
    ACFP_IDLE = 2'b00,
    ACFP_HPF  = 2'b01,
    ACFP_NTCH = 2'b10,
    ACFP_OUT  = 2'b11
  } acfp_state_t;
endpackage

// ===== logic/acfp_capture_path.sv
// capture-side decimation, high-pass, notch and volume path with apb registers
// Functional notes
// R01: path runs only while converter_on is one; reset leaves it off.
// R02: output_invert set negates every output sample.
// R03: oversample_select picks 64x or 128x; decimation ratio follows.
// R04: decimation accumulates modulator words with 24-bit precision per output sample.
// R05: highpass_on bypasses filter when zero; enabled after reset.
// R06: audio mode is first-order high-pass with very low cut-off.
// R07: application mode is second-order high-pass, cut-off by highpass_cutoff_sel.
// R08: application cut-off scales with sample rate; software sets sample_rate_sel.
// R09: two 14-bit notch coefficients, each split high seven and low seven.
// R10: notch applied only while notch_on set; off after reset.
// R11: active coefficients change only on a write with notch_commit high.
// R12: software sets notch_commit only on the last coefficient write.
// R13: software encodes coefficients negated, scaled by 2^13 and 2^12.
// R14: gain 0.5*(x-255) dB for codes 1..255, code 0 mutes.
// R15: attenuation -127 dB to 0 dB in half-dB steps; resets to 0 dB.
// R16: sample_rate_sel zero means 48 kHz; software matches actual rate.
// R17: committed coefficients load together at a sample boundary.
`timescale 1ns/10ps
`include "acfp_defs.svh"
module acfp_capture_path (
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic                 clk_en,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [7:0]           paddr,
  input  wire logic [31:0]          pwdata,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  wire logic                 mod_strobe,
  input  wire logic [5:0]           mod_data,
  output acfp_pkg::acfp_sample_t    sample_out,
  output logic                      converter_on
);
  logic [8:0]  pwr2_ff, ctrl_ff, vol_ff, rate_ff;
  logic [8:0]  na0h_ff, na0l_ff, na1h_ff, na1l_ff;
  logic [13:0] act_a0_ff, act_a1_ff;
  logic        commit_pend_ff;
  logic        strobe_s1_ff, strobe_s2_ff, strobe_s3_ff;
  logic [5:0]  data_s1_ff, data_s2_ff;
  logic [7:0]  dec_cnt_ff;
  logic [23:0] acc_ff;
  logic [23:0] dec_ff;
  acfp_pkg::acfp_state_t state_ff;
  logic [23:0] hp_x1_ff, hp_y1_ff, hp_y2_ff, hp_x2_ff;
  logic [23:0] hp_ff, nt_ff;
  logic [23:0] nt_x1_ff, nt_x2_ff, nt_y1_ff, nt_y2_ff;
  acfp_pkg::acfp_sample_t out_ff;
  logic        wr_en, rd_en;
  logic [5:0]  idx;
  logic        mapped;
  logic        commit_wr;
  logic [7:0]  ratio;
  logic        mod_tick;
  logic        last_tick;
  logic [23:0] nxt_acc;
  assign idx       = paddr[7:2];
  assign wr_en     = psel && penable && pwrite && clk_en;
  assign rd_en     = psel && !pwrite;
  assign pready    = 1'b1;
  assign converter_on = pwr2_ff[`ACFP_BIT_ON];
  assign sample_out   = out_ff;
  always_comb
  begin
    mapped = (paddr[1:0] == 2'b00) &&
             (idx == `ACFP_IDX_PWR2 || idx == `ACFP_IDX_CTRL || idx == `ACFP_IDX_VOL ||
              idx == `ACFP_IDX_RATE || idx == `ACFP_IDX_NA0H || idx == `ACFP_IDX_NA0L ||
              idx == `ACFP_IDX_NA1H || idx == `ACFP_IDX_NA1L);
  end
  assign pslverr   = psel && penable && !mapped;
  assign commit_wr = wr_en && mapped && pwdata[`ACFP_BIT_COMMIT] &&
                     (idx == `ACFP_IDX_NA0H || idx == `ACFP_IDX_NA0L ||
                      idx == `ACFP_IDX_NA1H || idx == `ACFP_IDX_NA1L);
  // register writes
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pwr2_ff <= `ACFP_RST_PWR2;
      ctrl_ff <= `ACFP_RST_CTRL;
      vol_ff  <= `ACFP_RST_VOL;
      rate_ff <= `ACFP_RST_RATE;
      na0h_ff <= `ACFP_RST_NOTCH;
      na0l_ff <= `ACFP_RST_NOTCH;
      na1h_ff <= `ACFP_RST_NOTCH;
      na1l_ff <= `ACFP_RST_NOTCH;
    end
    else if (wr_en && mapped)
    begin
      case (idx)
        `ACFP_IDX_PWR2: pwr2_ff <= pwdata[8:0];
        `ACFP_IDX_CTRL: ctrl_ff <= pwdata[8:0];
        `ACFP_IDX_VOL:  vol_ff  <= {1'b0, pwdata[7:0]};
        `ACFP_IDX_RATE: rate_ff <= {6'h00, pwdata[2:0]};
        `ACFP_IDX_NA0H: na0h_ff <= {1'b0, pwdata[7:0]};      // [R09]
        `ACFP_IDX_NA0L: na0l_ff <= {2'b00, pwdata[6:0]};     // [R09]
        `ACFP_IDX_NA1H: na1h_ff <= {2'b00, pwdata[6:0]};     // [R09]
        `ACFP_IDX_NA1L: na1l_ff <= {2'b00, pwdata[6:0]};     // [R09]
        default:        pwr2_ff <= pwr2_ff;
      endcase
    end
  end
  // read mux
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (clk_en && rd_en && !penable)
    begin
      case (idx)
        `ACFP_IDX_PWR2: prdata <= {23'h00_0000, pwr2_ff};
        `ACFP_IDX_CTRL: prdata <= {23'h00_0000, ctrl_ff};
        `ACFP_IDX_VOL:  prdata <= {23'h00_0000, vol_ff};
        `ACFP_IDX_RATE: prdata <= {23'h00_0000, rate_ff};
        `ACFP_IDX_NA0H: prdata <= {23'h00_0000, na0h_ff};
        `ACFP_IDX_NA0L: prdata <= {23'h00_0000, na0l_ff};
        `ACFP_IDX_NA1H: prdata <= {23'h00_0000, na1h_ff};
        `ACFP_IDX_NA1L: prdata <= {23'h00_0000, na1l_ff};
        default:        prdata <= 32'h0000_0000;
      endcase
    end
  end
  // staged coefficients move to active set at a sample boundary
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      commit_pend_ff <= 1'b0;
      act_a0_ff      <= 14'h0000;
      act_a1_ff      <= 14'h0000;
    end
    else if (clk_en)
    begin
      if (state_ff == acfp_pkg::ACFP_IDLE && commit_pend_ff)
      begin
        act_a0_ff      <= {na0h_ff[6:0], na0l_ff[6:0]};   // [R11] [R17]
        act_a1_ff      <= {na1h_ff[6:0], na1l_ff[6:0]};   // [R17]
        commit_pend_ff <= commit_wr;
      end
      else if (commit_wr)
        commit_pend_ff <= 1'b1;                           // [R11]
    end
  end
  // modulator input synchroniser
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      strobe_s1_ff <= 1'b0;
      strobe_s2_ff <= 1'b0;
      strobe_s3_ff <= 1'b0;
      data_s1_ff   <= 6'h00;
      data_s2_ff   <= 6'h00;
    end
    else if (clk_en)
    begin
      strobe_s1_ff <= mod_strobe;
      strobe_s2_ff <= strobe_s1_ff;
      strobe_s3_ff <= strobe_s2_ff;
      data_s1_ff   <= mod_data;
      data_s2_ff   <= data_s1_ff;
    end
  end
  assign mod_tick  = strobe_s2_ff && !strobe_s3_ff && converter_on;          // [R01]
  assign ratio     = ctrl_ff[`ACFP_BIT_OSR] ? `ACFP_OSR_HI : `ACFP_OSR_LO;   // [R03]
  assign last_tick = mod_tick && (dec_cnt_ff == ratio - 8'h01);
  assign nxt_acc   = acc_ff + {{18{data_s2_ff[5]}}, data_s2_ff};
  // decimating accumulator
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      dec_cnt_ff <= 8'h00;
      acc_ff     <= 24'h00_0000;
      dec_ff     <= 24'h00_0000;
    end
    else if (clk_en)
    begin
      if (!converter_on)
      begin
        dec_cnt_ff <= 8'h00;                              // [R01]
        acc_ff     <= 24'h00_0000;
      end
      else if (last_tick)
      begin
        dec_cnt_ff <= 8'h00;
        acc_ff     <= 24'h00_0000;
        dec_ff     <= ctrl_ff[`ACFP_BIT_OSR] ? {nxt_acc[22:0], 1'b0} :
                      {nxt_acc[21:0], 2'b00};             // [R03] [R04]
      end
      else if (mod_tick)
      begin
        dec_cnt_ff <= dec_cnt_ff + 8'h01;
        acc_ff     <= nxt_acc;                            // [R04]
      end
    end
  end
  // sequencer
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state_ff <= acfp_pkg::ACFP_IDLE;
    else if (clk_en)
    begin
      case (state_ff)
        acfp_pkg::ACFP_IDLE: if (last_tick) state_ff <= acfp_pkg::ACFP_HPF;
        acfp_pkg::ACFP_HPF:  state_ff <= acfp_pkg::ACFP_NTCH;
        acfp_pkg::ACFP_NTCH: state_ff <= acfp_pkg::ACFP_OUT;
        acfp_pkg::ACFP_OUT:  state_ff <= acfp_pkg::ACFP_IDLE;
        default:             state_ff <= acfp_pkg::ACFP_IDLE;
      endcase
    end
  end
  // high-pass: first order leaky in audio mode, second order in application mode
  logic [23:0] hp1, hp2a, hp2b;
  logic [3:0]  app_shift;
  assign app_shift = 4'd7 - {1'b0, ctrl_ff[6:4]};         // [R07] [R08]
  assign hp1  = dec_ff - hp_x1_ff + hp_y1_ff -
                24'($signed(hp_y1_ff) >>> `ACFP_AUDIO_SHIFT);                // [R06]
  assign hp2a = dec_ff - hp_x1_ff + hp_y1_ff - 24'($signed(hp_y1_ff) >>> app_shift);
  assign hp2b = hp2a - hp_x2_ff + hp_y2_ff - 24'($signed(hp_y2_ff) >>> app_shift);
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      hp_x1_ff <= 24'h00_0000;
      hp_y1_ff <= 24'h00_0000;
      hp_x2_ff <= 24'h00_0000;
      hp_y2_ff <= 24'h00_0000;
      hp_ff    <= 24'h00_0000;
    end
    else if (clk_en && state_ff == acfp_pkg::ACFP_HPF)
    begin
      hp_x1_ff <= dec_ff;
      if (!ctrl_ff[`ACFP_BIT_HPON])
        hp_ff <= dec_ff;                                  // [R05]
      else if (!ctrl_ff[`ACFP_BIT_HPAPP])
      begin
        hp_y1_ff <= hp1;
        hp_ff    <= hp1;                                  // [R06]
      end
      else
      begin
        hp_y1_ff <= hp2a;
        hp_x2_ff <= hp2a;
        hp_y2_ff <= hp2b;
        hp_ff    <= hp2b;                                 // [R07]
      end
    end
  end
  // notch: allpass-based, y = (x + ap)/2 with coefficients from active set
  logic signed [37:0] ap_sum;
  logic        [23:0] ap_out;
  assign ap_sum = ($signed({{14{nt_x2_ff[23]}}, nt_x2_ff}) <<< 13)
                + (($signed(act_a1_ff) * $signed(nt_y1_ff - nt_x1_ff)) <<< 1)
                + $signed(act_a0_ff) * $signed(nt_y2_ff - hp_ff);        // [R09]
  assign ap_out = ap_sum[36:13];
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      nt_x1_ff <= 24'h00_0000;
      nt_x2_ff <= 24'h00_0000;
      nt_y1_ff <= 24'h00_0000;
      nt_y2_ff <= 24'h00_0000;
      nt_ff    <= 24'h00_0000;
    end
    else if (clk_en && state_ff == acfp_pkg::ACFP_NTCH)
    begin
      nt_x1_ff <= hp_ff;
      nt_x2_ff <= nt_x1_ff;
      nt_y1_ff <= ap_out;
      nt_y2_ff <= nt_y1_ff;
      if (na0h_ff[`ACFP_BIT_NFON])
        nt_ff <= 24'(($signed({hp_ff[23], hp_ff}) +
                      $signed({ap_out[23], ap_out})) >>> 1);  // [R10]
      else
        nt_ff <= hp_ff;                                   // [R10]
    end
  end
  // volume: half-dB steps via 6 dB shifts and a sixteenth-step mantissa table
  logic [7:0]  atten;
  logic [28:0] scaled;
  logic [23:0] vol_out;
  assign atten = 8'hff - vol_ff[7:0];                     // [R14] [R15]
  logic [7:0] atten_div;
  logic [3:0] atten_rem;
  assign atten_div = atten / 8'd12;
  assign atten_rem = 4'(atten % 8'd12);
  logic [4:0] mant_r;
  always_comb
  begin
    case (atten_rem)
      4'd0:    mant_r = 5'd16;
      4'd1:    mant_r = 5'd15;
      4'd2:    mant_r = 5'd15;
      4'd3:    mant_r = 5'd14;
      4'd4:    mant_r = 5'd13;
      4'd5:    mant_r = 5'd13;
      4'd6:    mant_r = 5'd11;
      4'd7:    mant_r = 5'd11;
      4'd8:    mant_r = 5'd10;
      4'd9:    mant_r = 5'd10;
      4'd10:   mant_r = 5'd9;
      default: mant_r = 5'd9;
    endcase
  end
  assign scaled  = 29'($signed({{5{nt_ff[23]}}, nt_ff}) * $signed({1'b0, mant_r}));
  assign vol_out = (atten_div > 8'd23) ? 24'h00_0000 :
                   24'($signed(scaled) >>> (5'd4 + atten_div[4:0]));         // [R15]
  // output stage
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      out_ff <= '0;
    else if (clk_en)
    begin
      out_ff.valid <= (state_ff == acfp_pkg::ACFP_OUT) && converter_on;      // [R01]
      if (state_ff == acfp_pkg::ACFP_OUT && converter_on)
      begin
        if (vol_ff[7:0] == 8'h00)
          out_ff.data <= 24'h00_0000;                     // [R14]
        else if (ctrl_ff[`ACFP_BIT_INV])
          out_ff.data <= 24'h00_0000 - vol_out;           // [R02]
        else
          out_ff.data <= vol_out;                         // [R02]
      end
    end
  end
  logic unused_ok;
  assign unused_ok = |{rate_ff, na0h_ff[8], pwdata[31:9]};
endmodule

// ===== testbench/acfp_capture_path_properties.sv
// port assertions for the capture path
`timescale 1ns/10ps
module acfp_capture_path_properties (
  input wire logic                   pclk,
  input wire logic                   presetn,
  input wire logic                   clk_en,
  input wire logic                   psel,
  input wire logic                   penable,
  input wire logic                   pwrite,
  input wire logic [7:0]             paddr,
  input wire logic [31:0]            pwdata,
  input wire logic [31:0]            prdata,
  input wire logic                   pready,
  input wire logic                   pslverr,
  input wire logic                   mod_strobe,
  input wire logic [5:0]             mod_data,
  input wire acfp_pkg::acfp_sample_t sample_out,
  input wire logic                   converter_on
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire logic acc = psel && penable && clk_en;
  logic      on_ff;
  // expected enable bit from observed writes
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      on_ff <= 1'b0;
    else if (acc && pwrite && paddr == 8'h08)
      on_ff <= pwdata[0];
  end
  a_ready_high: assert property (psel && penable |-> pready)
    else $error("pready low in access");
  a_bad_addr: assert property (psel && penable && paddr == 8'h00 |-> pslverr)
    else $error("no error on unmapped");
  a_good_addr: assert property (psel && penable && paddr == 8'h38 |-> !pslverr)
    else $error("error on mapped");
  a_read_upper: assert property (acc && !pwrite && $past(clk_en) |-> prdata[31:9] == 23'h00_0000)
    else $error("upper read bits set");
  a_on_tracks: assert property (converter_on != on_ff |=> converter_on == on_ff)
    else $error("enable output lags");
  a_read_on: assert property (acc && !pwrite && $past(clk_en) && paddr == 8'h08 |->
    prdata[0] == on_ff)
    else $error("enable readback");
  a_off_quiet: assert property ((!converter_on) [*5] |-> !sample_out.valid)
    else $error("sample while off");
  a_valid_pulse: assert property (sample_out.valid && clk_en |=> !sample_out.valid)
    else $error("valid too long");
  a_data_holds: assert property (!sample_out.valid |-> $stable(sample_out.data))
    else $error("data moved");
endmodule
bind acfp_capture_path acfp_capture_path_properties acfp_capture_path_properties_i (
  .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .mod_strobe(mod_strobe), .mod_data(mod_data),
  .sample_out(sample_out), .converter_on(converter_on));

// ===== testbench/acfp_mod_source.sv
// modulator word source for the stream input
`timescale 1ns/10ps
module acfp_mod_source (
  input  wire logic       pclk,
  output logic            mod_strobe,
  output logic [5:0]      mod_data
);
  initial
  begin
    mod_strobe = 1'b0;
    mod_data   = 6'h2a;
  end
  // n words of value v, strobe two high and four low
  task automatic send(input int n, input logic [5:0] v);
    repeat (n)
    begin
      @(posedge pclk);
      mod_data <= v;
      @(posedge pclk);
      mod_strobe <= 1'b1;
      repeat (2) @(posedge pclk);
      mod_strobe <= 1'b0;
      repeat (2) @(posedge pclk);
      mod_data <= ~v;
    end
  endtask
endmodule

// ===== testbench/test_acfp_capture_path.sv
// self-checking bench for the capture path
`timescale 1ns/10ps
`include "acfp_defs.svh"
module test_acfp_capture_path;
  logic                   pclk = 1'b0;
  logic                   presetn, clk_en, psel, penable, pwrite, pready, pslverr;
  logic                   mod_strobe, converter_on, e;
  logic [7:0]             paddr;
  logic [31:0]            pwdata, prdata, q;
  logic [5:0]             mod_data;
  logic [23:0]            last_data;
  acfp_pkg::acfp_sample_t sample_out;
  int                     n_mismatch = 0, checks = 0, n_valid = 0;
  always #50 pclk = ~pclk;
  acfp_capture_path acfp_capture_path_i (
    .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .mod_strobe(mod_strobe), .mod_data(mod_data),
    .sample_out(sample_out), .converter_on(converter_on));
  acfp_mod_source acfp_mod_source_i (.pclk(pclk), .mod_strobe(mod_strobe),
    .mod_data(mod_data));
  always @(posedge pclk)
  begin
    if (sample_out.valid === 1'b1)
    begin
      n_valid++;
      last_data = sample_out.data;
    end
  end
  task automatic summarize();
    $display("mismatches %0d checks %0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic fail(input string m);
    n_mismatch++;
    $display("CHECK FAILED at %0t: %s", $time, m);
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] x, input string m);
    checks++;
    if (g !== x) fail(m);
  endtask
  task automatic chk_s(input logic [23:0] g, input logic [23:0] x);
    checks++;
    if (g !== x) fail("sample value");
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic er);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge pclk);
      k++;
    end
    while (pready !== 1'b1 && k < 16);
    r = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1)
    begin
      fail("bus timeout");
      summarize();
    end
  endtask
  task automatic wr(input logic [5:0] i, input logic [31:0] d);
    logic [31:0] r;
    logic        er;
    apb(1'b1, {i, 2'b00}, d, r, er);
  endtask
  task automatic rd(input logic [5:0] i, output logic [31:0] d);
    logic er;
    apb(1'b0, {i, 2'b00}, 32'h0000_0000, d, er);
  endtask
  task automatic wait_n(input int n);
    for (int k = 0; k < 200 && n_valid < n; k++) @(posedge pclk);
    chk(n_valid, n, "sample count");
    if (n_valid < n)
      summarize();
  endtask
  task automatic frame(input logic [8:0] c, input logic [8:0] g, input int n,
                       input logic [5:0] v, input logic [23:0] x);
    wr(`ACFP_IDX_PWR2, 32'h0000_0000);
    wr(`ACFP_IDX_CTRL, {23'h00_0000, c});
    wr(`ACFP_IDX_VOL, {23'h00_0000, g});
    wr(`ACFP_IDX_PWR2, 32'h0000_0001);
    n_valid = 0;
    acfp_mod_source_i.send(n, v);
    wait_n(1);
    chk_s(last_data, x);
  endtask
  initial
  begin
    presetn = 1'b0;
    clk_en = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    rd(`ACFP_IDX_PWR2, q);
    chk(q, 32'h0000_0000, "power reset");
    rd(`ACFP_IDX_CTRL, q);
    chk(q, 32'h0000_0100, "control reset");
    rd(`ACFP_IDX_VOL, q);
    chk(q, 32'h0000_00ff, "volume reset");
    for (int i = 0; i < 4; i++)
    begin
      rd(6'(`ACFP_IDX_NA0H + i), q);
      chk(q, 32'h0000_0000, "notch reset");
      wr(6'(`ACFP_IDX_NA0H + i), 32'h0000_007f);
      rd(6'(`ACFP_IDX_NA0H + i), q);
      chk(q, 32'h0000_007f, "notch half");
    end
    wr(`ACFP_IDX_NA1L, 32'h0000_017f);
    rd(`ACFP_IDX_NA1L, q);
    chk(q, 32'h0000_007f, "commit not stored");
    wr(`ACFP_IDX_NA0H, 32'h0000_0080);
    rd(`ACFP_IDX_NA0H, q);
    chk(q, 32'h0000_0080, "notch enable");
    wr(`ACFP_IDX_NA0H, 32'h0000_0000);
    wr(`ACFP_IDX_VOL, 32'h0000_01ab);
    rd(`ACFP_IDX_VOL, q);
    chk(q, 32'h0000_00ab, "volume width");
    wr(`ACFP_IDX_RATE, 32'h0000_01fd);
    rd(`ACFP_IDX_RATE, q);
    chk(q, 32'h0000_0005, "rate width");
    wr(`ACFP_IDX_RATE, 32'h0000_0000);
    clk_en <= 1'b0;
    wr(`ACFP_IDX_VOL, 32'h0000_0012);
    clk_en <= 1'b1;
    rd(`ACFP_IDX_VOL, q);
    chk(q, 32'h0000_00ab, "frozen write");
    apb(1'b0, 8'h00, 32'h0000_0000, q, e);
    chk({31'h0000_0000, e}, 32'h0000_0001, "unmapped error");
    chk(q, 32'h0000_0000, "unmapped data");
    apb(1'b1, 8'h39, 32'h0000_0000, q, e);
    chk({31'h0000_0000, e}, 32'h0000_0001, "unaligned error");
    frame(9'h000, 9'h0ff, 64, 6'h05, 24'h00_0500);
    frame(9'h001, 9'h0ff, 64, 6'h05, 24'hff_fb00);
    frame(9'h000, 9'h0ff, 64, 6'h3d, 24'hff_fd00);
    frame(9'h000, 9'h000, 64, 6'h05, 24'h00_0000);
    frame(9'h008, 9'h0ff, 128, 6'h05, 24'h00_0500);
    n_valid = 0;
    acfp_mod_source_i.send(64, 6'h05);
    repeat (10) @(posedge pclk);
    chk(n_valid, 0, "early sample");
    acfp_mod_source_i.send(64, 6'h05);
    wait_n(1);
    wr(`ACFP_IDX_PWR2, 32'h0000_0000);
    n_valid = 0;
    acfp_mod_source_i.send(64, 6'h05);
    repeat (10) @(posedge pclk);
    chk(n_valid, 0, "sample while off");
    chk({31'h0000_0000, converter_on}, 32'h0000_0000, "enable output");
    wr(`ACFP_IDX_PWR2, 32'h0000_0001);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd(`ACFP_IDX_PWR2, q);
    chk(q, 32'h0000_0000, "power second reset");
    wr(`ACFP_IDX_NA0L, 32'h0000_007f);
    wr(`ACFP_IDX_NA0H, 32'h0000_0080);
    frame(9'h000, 9'h0ff, 64, 6'h05, 24'h00_0280);
    summarize();
  end
endmodule
